/* rtl/icrl_cond_det.sv */
`timescale 1ns/10ps
module icrl_cond_det
(
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic enable_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      start_out,
   output logic      stop_out,
   output logic      scl_rise_out,
   output logic      scl_fall_out,
   output logic      busy_out
);

   logic scl_q;
   logic sda_q;
   logic busy_q;

   ////////////////////////////////////////////////////////////////////////////////
   // previous line levels, idle high
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   // conditions only reported while enabled
   assign start_out    = enable_in & scl_q & scl_in & sda_q & ~sda_in;
   assign stop_out     = enable_in & scl_q & scl_in & ~sda_q & sda_in;
   assign scl_rise_out = enable_in & ~scl_q & scl_in;
   assign scl_fall_out = enable_in & scl_q & ~scl_in;
   assign busy_out     = busy_q;

   ////////////////////////////////////////////////////////////////////////////////
   // bus busy: forgotten on disable, a fresh enable knows no traffic
   always_ff @(posedge clk_in)
   begin
      if (rst_in | ~enable_in)
         busy_q <= 1'b0;
      else if (start_out)
         busy_q <= 1'b1;
      else if (stop_out)
         busy_q <= 1'b0;
   end

endmodule : icrl_cond_det

/* rtl/icrl_pkg.sv */
package icrl_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [31:0] CTRL_ADDR     = 32'h0021_7008;
   localparam logic [31:0] STAT_ADDR     = 32'h0021_7010;
   localparam logic [31:0] IRQ_STAT_ADDR = 32'h0021_7014;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'h0021_7018;

   ////////////////////////////////////////////////////////////////////////////////
   // control register fields
   localparam int EN_BIT   = 7;
   localparam int IEN_BIT  = 6;
   localparam int MSEL_BIT = 5;
   localparam int DIR_BIT  = 4;
   localparam int ACKD_BIT = 3;
   localparam int REPEAT_START_REQUEST_BIT = 2;

   // status and interrupt status fields
   localparam int TC_BIT    = 7;
   localparam int AAS_BIT   = 6;
   localparam int BUSY_BIT  = 5;
   localparam int ARB_BIT   = 4;
   localparam int SRW_BIT   = 2;
   localparam int IFLAG_BIT = 1;
   localparam int RXAK_BIT  = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
   localparam logic       TC_RESET       = 1'b1;

   // bit counter codes
   localparam logic [3:0] BIT_ACK  = 4'h7;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] BIT_PRE  = 4'hF;

   // bit timing: half of a 100 kHz bit period, least time so rounded up
   localparam int CLK_PERIOD_NS   = 10;
   localparam int BIT_HALF_NS     = 5000;
   localparam int BIT_HALF_CYCLES = (BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0]
   {
      M_IDLE   = 3'b000,
      M_START  = 3'b001,
      M_HOLD   = 3'b010,
      M_LOW    = 3'b011,
      M_HIGH   = 3'b100,
      M_STOP   = 3'b101,
      M_RSTART = 3'b110
   } icrl_mstate_type;

endpackage : icrl_pkg

/* rtl/icrl_top.sv */
// Behaviour
// - enable bit 7 clear holds module in reset; registers stay accessible.
// - slave enabled mid-transfer ignores it and starts at next START.
// - master just enabled knows no busy bus; arbitration sorts it out.
// - interrupt enable bit 6 gates output with flag; clearing keeps pending events.
// - master select 0 to 1 issues START and master operation.
// - master select 1 to 0 issues STOP and returns to slave.
// - lost arbitration clears master select by hardware unless a control write other than a lost START comes in the same cycle, no STOP driven.
// - direction bit 4: 0 receive, 1 transmit, master and slave.
// - ack-disable bit 3: 0 drives ACK at ninth clock, 1 leaves high.
// - ack-disable only matters when this module receives.
// - writing repeat-start bit 2 makes repeated START; it reads 0.
// - repeated START without bus ownership counts as lost arbitration.
// - control bits 31-8 and 1-0 read zero.
// - any control register write clears addressed-as-slave flag unless an address match comes in the same cycle.
// - transfer-complete sets at falling edge of ninth clock.
`timescale 1ns/10ps
module icrl_top
#(
   parameter int HALF_CYCLES = icrl_pkg::BIT_HALF_CYCLES
)
(
   input  wire logic        CLK_IN,
   input  wire logic        RESET_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [31:0] PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   output logic      [31:0] PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   output logic             IRQ_OUT,
   input  wire logic [6:0]  SLAVE_ADDR_IN,
   input  wire logic [7:0]  TX_DATA_IN,
   input  wire logic        BYTE_GO_IN,
   output logic      [7:0]  RX_DATA_OUT,
   input  wire logic        SCL_IN,
   output logic             SCL_OUT,
   output logic             SCL_OE_OUT,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_OUT
);

   localparam logic [11:0] HALF_LD = 12'(HALF_CYCLES);

   icrl_pkg::icrl_mstate_type m_q;
   logic [1:0]  ph_q;
   logic [11:0] tmr_q;
   logic        en_q, ien_q, msel_q, dir_q, ackd_q;
   logic [7:0]  irq_stat_q, irq_mask_q, shift_q, rx_q;
   logic [31:0] prdata_q;
   logic [3:0]  bit_q;
   logic        listen_q, addr_ph_q, aas_q, srw_q, rxack_q, tc_q;
   logic        eng_sda_low_q, hold_q, m_scl_low_q, m_sda_low_q, stop_pend_q, repeat_start_request_pend_q;
   logic        start_det, stop_det, scl_rise, scl_fall, busy;

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states
   wire setup    = PSEL_IN & ~PENABLE_IN;
   wire access   = PSEL_IN & PENABLE_IN;
   wire hit_ctrl = PADDR_IN == icrl_pkg::CTRL_ADDR;
   wire hit_stat = PADDR_IN == icrl_pkg::STAT_ADDR;
   wire hit_ist  = PADDR_IN == icrl_pkg::IRQ_STAT_ADDR;
   wire hit_imsk = PADDR_IN == icrl_pkg::IRQ_MASK_ADDR;
   wire hit      = hit_ctrl | hit_stat | hit_ist | hit_imsk;
   wire wr       = access & PWRITE_IN & hit;
   wire ctrl_wr  = wr & hit_ctrl;
   wire ist_rd   = access & ~PWRITE_IN & hit_ist;

   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = access & ~hit;
   assign PRDATA_OUT  = prdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // control requests need enable already set
   wire start_req = ctrl_wr & en_q & PWDATA_IN[icrl_pkg::MSEL_BIT] & ~msel_q;
   wire stop_req  = ctrl_wr & en_q & ~PWDATA_IN[icrl_pkg::MSEL_BIT] & msel_q;
   wire repeat_start_request_wr   = ctrl_wr & en_q & PWDATA_IN[icrl_pkg::REPEAT_START_REQUEST_BIT];
   wire m_own     = m_q != icrl_pkg::M_IDLE;

   // busy knows only traffic since enable; start on busy bus loses
   wire start_lost = start_req & busy;
   // repeat start while not owning the bus
   wire repeat_start_request_lost  = repeat_start_request_wr & ~m_own;

   // slave joins only after a START it saw
   wire part     = m_own | (listen_q & (addr_ph_q | aas_q));
   wire eng_act  = part & ~start_det & ~stop_det;
   wire addr_hit = shift_q[7:1] == SLAVE_ADDR_IN;
   wire data_bit = bit_q < icrl_pkg::BIT_LAST;

   wire tx_now = dir_q;

   wire arb_bit   = eng_act & scl_rise & m_own & tx_now & data_bit
                    & ~eng_sda_low_q & ~m_sda_low_q & ~SDA_IN;
   wire arb_evt   = arb_bit | start_lost | repeat_start_request_lost;
   wire ninth     = eng_act & scl_fall & (bit_q == icrl_pkg::BIT_LAST);
   wire match_evt = eng_act & scl_fall & (bit_q == icrl_pkg::BIT_ACK) & addr_ph_q & addr_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // bus condition detector
   icrl_cond_det u_det
   (
      .clk_in       (CLK_IN),
      .rst_in       (RESET_IN),
      .enable_in    (en_q),
      .scl_in       (SCL_IN),
      .sda_in       (SDA_IN),
      .start_out    (start_det),
      .stop_out     (stop_det),
      .scl_rise_out (scl_rise),
      .scl_fall_out (scl_fall),
      .busy_out     (busy)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // control register; only bits 7..2 exist, repeat start is not stored
   always_ff @(posedge CLK_IN)
   begin
      if (RESET_IN)
      begin
         en_q   <= 1'b0;
         ien_q  <= 1'b0;
         msel_q <= 1'b0;
         dir_q  <= 1'b0;
         ackd_q <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         en_q   <= PWDATA_IN[icrl_pkg::EN_BIT];
         ien_q  <= PWDATA_IN[icrl_pkg::IEN_BIT];
         msel_q <= PWDATA_IN[icrl_pkg::MSEL_BIT] & ~start_lost;
         dir_q  <= PWDATA_IN[icrl_pkg::DIR_BIT];
         ackd_q <= PWDATA_IN[icrl_pkg::ACKD_BIT];
      end
      // hardware drops master select on lost arbitration; a control write in the same cycle wins, except a START lost on a busy bus
      else if (arb_evt)
         msel_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data captured in setup, stable through access
   wire        iflag   = |(irq_stat_q & irq_mask_q);
   wire [31:0] ctrl_rd = {24'h000000, en_q, ien_q, msel_q, dir_q, ackd_q, 3'h0};
   wire [31:0] stat_rd = {24'h000000, tc_q, aas_q, busy, irq_stat_q[icrl_pkg::ARB_BIT],
                          1'b0, srw_q, iflag, rxack_q};
   wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                         hit_stat ? stat_rd :
                         hit_ist  ? {24'h000000, irq_stat_q} :
                         hit_imsk ? {24'h000000, irq_mask_q} : 32'h00000000;

   always_ff @(posedge CLK_IN)
   begin
      if (RESET_IN)
         prdata_q <= 32'h00000000;
      else if (setup & ~PWRITE_IN)
         prdata_q <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read clears returned bits; a new event wins
   wire [7:0] evt = {ninth, match_evt, 1'b0, arb_evt, 4'h0};
   wire [7:0] clr = ist_rd ? prdata_q[7:0] : 8'h00;

   always_ff @(posedge CLK_IN)
   begin
      if (RESET_IN)
      begin
         irq_stat_q <= 8'h00;
         irq_mask_q <= icrl_pkg::IRQ_MASK_RESET;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~clr) | evt;
         if (wr & hit_imsk)
            irq_mask_q <= PWDATA_IN[7:0];
      end
   end

   // interrupt enable gates the output only; pending bits stay
   assign IRQ_OUT = en_q & ien_q & iflag;

   ////////////////////////////////////////////////////////////////////////////////
   // master sequencer; timer stops when idle, holding or stretched
   wire tick     = tmr_q == 12'h000;
   wire tmr_hold = (m_q == icrl_pkg::M_IDLE) | (m_q == icrl_pkg::M_HOLD) | (~m_scl_low_q & ~SCL_IN);

   always_ff @(posedge CLK_IN)
   begin
      // disable idles the sequencer; lost arbitration leaves without STOP
      if (RESET_IN | ~en_q | arb_evt)
      begin
         m_q         <= icrl_pkg::M_IDLE;
         ph_q        <= 2'h0;
         tmr_q       <= HALF_LD;
         m_scl_low_q <= 1'b0;
         m_sda_low_q <= 1'b0;
         stop_pend_q <= 1'b0;
         repeat_start_request_pend_q <= 1'b0;
      end
      else
      begin
         tmr_q <= (tick | tmr_hold) ? HALF_LD : tmr_q - 12'h001;
         if (stop_req)
            stop_pend_q <= 1'b1;
         if (repeat_start_request_wr)
            repeat_start_request_pend_q <= 1'b1;
         case (m_q)
            // rising master select pulls SDA low with SCL high
            icrl_pkg::M_IDLE:
               if (start_req)
               begin
                  m_sda_low_q <= 1'b1;
                  m_q         <= icrl_pkg::M_START;
               end
            icrl_pkg::M_START:
               if (tick)
               begin
                  m_scl_low_q <= 1'b1;
                  m_q         <= icrl_pkg::M_HOLD;
               end
            // STOP or restart acted on between bytes only
            icrl_pkg::M_HOLD:
               if (stop_pend_q)
               begin
                  stop_pend_q <= 1'b0;
                  m_sda_low_q <= 1'b1;
                  ph_q        <= 2'h0;
                  m_q         <= icrl_pkg::M_STOP;
               end
               else if (repeat_start_request_pend_q)
               begin
                  repeat_start_request_pend_q <= 1'b0;
                  m_sda_low_q <= 1'b0;
                  ph_q        <= 2'h0;
                  m_q         <= icrl_pkg::M_RSTART;
               end
               else if (BYTE_GO_IN)
               begin
                  m_sda_low_q <= 1'b0;
                  m_q         <= icrl_pkg::M_LOW;
               end
            icrl_pkg::M_LOW:
               if (tick)
               begin
                  m_scl_low_q <= 1'b0;
                  m_q         <= icrl_pkg::M_HIGH;
               end
            icrl_pkg::M_HIGH:
               if (tick)
               begin
                  m_scl_low_q <= 1'b1;
                  m_q         <= (bit_q == icrl_pkg::BIT_LAST) ? icrl_pkg::M_HOLD : icrl_pkg::M_LOW;
               end
            // falling master select: release SCL, then SDA while SCL high
            icrl_pkg::M_STOP:
               if (tick)
               begin
                  ph_q <= ph_q + 2'h1;
                  if (ph_q == 2'h0)
                     m_scl_low_q <= 1'b0;
                  else
                  begin
                     m_sda_low_q <= 1'b0;
                     m_q         <= icrl_pkg::M_IDLE;
                  end
               end
            // release SCL, pull SDA low while high, then SCL low again
            icrl_pkg::M_RSTART:
               if (tick)
               begin
                  ph_q <= ph_q + 2'h1;
                  if (ph_q == 2'h0)
                     m_scl_low_q <= 1'b0;
                  else if (ph_q == 2'h1)
                     m_sda_low_q <= 1'b1;
                  else
                  begin
                     m_scl_low_q <= 1'b1;
                     m_q         <= icrl_pkg::M_HOLD;
                  end
               end
            default:
               m_q <= icrl_pkg::M_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // byte engine for master and slave, stepped by SCL edges
   always_ff @(posedge CLK_IN)
   begin
      // disable clears all protocol state and releases the lines
      if (RESET_IN | ~en_q)
      begin
         bit_q         <= icrl_pkg::BIT_PRE;
         shift_q       <= 8'h00;
         rx_q          <= 8'h00;
         listen_q      <= 1'b0;
         addr_ph_q     <= 1'b0;
         aas_q         <= 1'b0;
         srw_q         <= 1'b0;
         rxack_q       <= 1'b1;
         tc_q          <= icrl_pkg::TC_RESET;
         eng_sda_low_q <= 1'b0;
         hold_q        <= 1'b0;
      end
      else
      begin
         // control write clears address flag; a match wins
         if (ctrl_wr)
            aas_q <= 1'b0;
         if (arb_evt)
            eng_sda_low_q <= 1'b0;
         // a START arms the slave unless master, the old byte is dropped
         if (start_det)
         begin
            bit_q     <= icrl_pkg::BIT_PRE;
            listen_q  <= ~m_own;
            addr_ph_q <= ~m_own;
         end
         else if (stop_det)
         begin
            listen_q      <= 1'b0;
            hold_q        <= 1'b0;
            eng_sda_low_q <= 1'b0;
         end
         else
         begin
            if (BYTE_GO_IN & (hold_q | m_own))
            begin
               shift_q       <= TX_DATA_IN;
               eng_sda_low_q <= tx_now & ~TX_DATA_IN[7];
               hold_q        <= 1'b0;
               tc_q          <= 1'b0;
            end
            if (eng_act & scl_rise & data_bit)
               shift_q <= {shift_q[6:0], SDA_IN};
            if (eng_act & scl_rise & ~data_bit)
               rxack_q <= SDA_IN;
            if (eng_act & scl_fall)
            begin
               if (bit_q == icrl_pkg::BIT_PRE)
                  bit_q <= 4'h0;
               else if (bit_q == icrl_pkg::BIT_ACK)
               begin
                  bit_q <= icrl_pkg::BIT_LAST;
                  if (addr_ph_q)
                  begin
                     addr_ph_q     <= 1'b0;
                     listen_q      <= addr_hit;
                     eng_sda_low_q <= addr_hit;
                     if (addr_hit)
                     begin
                        aas_q <= 1'b1;
                        srw_q <= shift_q[0];
                     end
                  end
                  // drive ACK unless disabled; only as receiver
                  else
                     eng_sda_low_q <= ~tx_now & ~ackd_q;
               end
               // ninth fall completes the byte; slave stretches
               else if (bit_q == icrl_pkg::BIT_LAST)
               begin
                  bit_q         <= 4'h0;
                  tc_q          <= 1'b1;
                  rx_q          <= shift_q;
                  eng_sda_low_q <= 1'b0;
                  hold_q        <= ~m_own;
               end
               else
               begin
                  bit_q         <= bit_q + 4'h1;
                  eng_sda_low_q <= tx_now & ~shift_q[7];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // open-drain pins: only ever pulled low
   assign SCL_OUT     = 1'b0;
   assign SDA_OUT     = 1'b0;
   assign SCL_OE_OUT  = m_scl_low_q | hold_q;
   assign SDA_OE_OUT  = m_sda_low_q | eng_sda_low_q;
   assign RX_DATA_OUT = rx_q;

endmodule : icrl_top

/* sim/icrl_bus_slave.sv */
`timescale 1ns/10ps
module icrl_bus_slave
#(
   parameter logic [6:0] ADDR = 7'h2A
)
(
   input  wire logic       clk_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [7:0] tx_in,
   input  wire logic [3:0] stretch_in,
   output logic            scl_oe_out,
   output logic            sda_oe_out = 1'b0
);
   logic       scl_p = 1'b1;
   logic       sda_p = 1'b1;
   logic       sel = 1'b0;
   logic       rd = 1'b0;
   logic       adr = 1'b1;
   logic       last_ack = 1'b1;
   logic [7:0] sh = 8'h00;
   logic [7:0] got[$];
   int         bitn = 0;
   int         hold = 0;
   int         n_start = 0;
   int         n_stop = 0;
   // slow answer stretches SCL after each byte
   assign scl_oe_out = hold > 0;
   ////////////////////////////////////////
   // watches the lines; lets go of SDA once refused
   always @(posedge clk_in)
   begin
      if (hold > 0)
         hold = hold - 1;
      if (scl_in && scl_p && sda_p && !sda_in)
      begin
         n_start++;
         bitn = 0;
         adr = 1'b1;
         sel = 1'b0;
         sda_oe_out <= 1'b0;
      end
      else if (scl_in && scl_p && !sda_p && sda_in)
      begin
         n_stop++;
         sel = 1'b0;
         sda_oe_out <= 1'b0;
      end
      else if (scl_in && !scl_p)
      begin
         if (bitn < 8)
            sh = {sh[6:0], sda_in};
         else
            last_ack = sda_in;
         bitn++;
      end
      else if (!scl_in && scl_p)
      begin
         if (bitn == 9)
         begin
            bitn = 0;
            adr = 1'b0;
            hold = stretch_in;
            if (rd && last_ack)
               sel = 1'b0;
         end
         if (bitn == 8 && adr)
         begin
            sel = sh[7:1] == ADDR;
            rd = sh[0];
         end
         else if (bitn == 8 && sel && !rd)
            got.push_back(sh);
         sda_oe_out <= bitn == 8 ? sel && (adr || !rd) : sel && rd && !adr && !tx_in[7 - bitn];
      end
      scl_p = scl_in;
      sda_p = sda_in;
   end
endmodule : icrl_bus_slave

/* sim/icrl_chk.sv */
`timescale 1ns/10ps
module icrl_chk
#(
   parameter int HALF_CYCLES = 6
)
(
   input wire logic        CLK_IN,
   input wire logic        RESET_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [31:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic        IRQ_OUT,
   input wire logic        SCL_IN,
   input wire logic        SCL_OE_OUT,
   input wire logic        SDA_IN,
   input wire logic        SDA_OE_OUT
);
   localparam int SCL_DLY = HALF_CYCLES + 1;
   logic [7:0] ctl_q;
   // decode; start counts on idle bus, module on
   wire acc = PSEL_IN && PENABLE_IN;
   wire hit = PADDR_IN == icrl_pkg::CTRL_ADDR || PADDR_IN == icrl_pkg::STAT_ADDR
              || PADDR_IN == icrl_pkg::IRQ_STAT_ADDR || PADDR_IN == icrl_pkg::IRQ_MASK_ADDR;
   wire cwr = acc && PWRITE_IN && PADDR_IN == icrl_pkg::CTRL_ADDR;
   wire crd = acc && !PWRITE_IN && PADDR_IN == icrl_pkg::CTRL_ADDR;
   wire go  = cwr && PWDATA_IN[7] && PWDATA_IN[5] && ctl_q[7] && !ctl_q[5] && SCL_IN && SDA_IN;
   ////////////////////////////////////////
   // last written control byte; hardware may clear master select
   always_ff @(posedge CLK_IN)
   begin
      if (RESET_IN)
         ctl_q <= 8'h00;
      else if (cwr)
         ctl_q <= PWDATA_IN[7:0];
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RESET_IN);
   // SDA pulled first, SCL one half period later
   sequence start_seq;
      SDA_OE_OUT && !SCL_OE_OUT ##SCL_DLY $rose(SCL_OE_OUT);
   endsequence
   ////////////////////////////////////////
   unmapped_err_a: assert property (acc && !hit |-> PSLVERR_OUT)
      else $error("unmapped not refused");
   mapped_ok_a: assert property (acc && hit |-> !PSLVERR_OUT)
      else $error("mapped refused");
   ctrl_zero_a: assert property (crd |-> PRDATA_OUT[31:8] == 24'h000000 && PRDATA_OUT[2:0] == 3'h0)
      else $error("reserved bits nonzero");
   ctrl_keep_a: assert property (crd |-> {PRDATA_OUT[7:6], PRDATA_OUT[4:3]} == {ctl_q[7:6], ctl_q[4:3]})
      else $error("control bits not kept");
   irq_gate_a: assert property (IRQ_OUT |-> ctl_q[7] && ctl_q[6])
      else $error("irq without enables");
   off_idle_a: assert property (!ctl_q[7] && !$past(ctl_q[7]) |-> !SCL_OE_OUT && !SDA_OE_OUT)
      else $error("disabled drives bus");
   start_gen_a: assert property (go |=> start_seq)
      else $error("no start");
   stop_only_a: assert property ($fell(SDA_OE_OUT) && SCL_IN && ctl_q[7] |-> !ctl_q[5])
      else $error("stop while master");
endmodule : icrl_chk

bind icrl_top icrl_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk
(
   .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT), .SCL_IN(SCL_IN), .SCL_OE_OUT(SCL_OE_OUT),
   .SDA_IN(SDA_IN), .SDA_OE_OUT(SDA_OE_OUT)
);

/* sim/tb_i2c_control_register_logic.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_errors++; \
   $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tb_i2c_control_register_logic;
   localparam int         HALF = 6;
   localparam logic [6:0] PEER = 7'h2A;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, err;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, v, rd;
   logic [7:0]  txd = 8'h00, direction_transmit = 8'h00, b, sent[$];
   logic [6:0]  saddr = 7'h40;
   logic [3:0]  mstr = 4'h0;
   logic [31:0] prdata;
   logic [7:0]  rxd;
   logic        pready, pslverr, irq, scl_oe, sda_oe, m_scl_oe, m_sda_oe;
   int          i, k, n, seed, cyc = 0, n_errors = 0, num_checks = 0;
   // open-drain lines with pull-ups
   wire scl = !(scl_oe || m_scl_oe);
   wire sda = !(sda_oe || m_sda_oe);
   icrl_top #(.HALF_CYCLES(HALF)) dut
   (
      .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .SLAVE_ADDR_IN(saddr), .TX_DATA_IN(txd),
      .BYTE_GO_IN(go), .RX_DATA_OUT(rxd), .SCL_IN(scl), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
      .SDA_IN(sda), .SDA_OUT(), .SDA_OE_OUT(sda_oe)
   );
   icrl_bus_slave #(.ADDR(PEER)) peer
   (
      .clk_in(clk), .scl_in(scl), .sda_in(sda), .tx_in(direction_transmit), .stretch_in(mstr),
      .scl_oe_out(m_scl_oe), .sda_oe_out(m_sda_oe)
   );
   ////////////////////////////////////////
   // clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   // one transfer; waits an edge so no signal is driven twice
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [31:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
   endtask : rchk
   // one byte from hold; done when status shows complete
   task automatic byte_go(input logic [7:0] d);
      for (k = 0; k < 3000 && scl_oe !== 1'b1; k++) @(posedge clk);
      repeat (2) @(posedge clk);
      txd <= d;
      go  <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
      rd = 32'h0;
      for (k = 0; k < 400 && rd[7] !== 1'b1; k++) apb(1'b0, icrl_pkg::STAT_ADDR, 32'h0);
   endtask : byte_go
   ////////////////////////////////////////
   initial
   begin
      seed = 53;
      repeat (3) @(posedge clk);
      rst   <= 1'b0;
      saddr <= 7'h40 | 7'($random(seed));
      rchk(icrl_pkg::CTRL_ADDR, 32'h0, "ctrl reset");
      rchk(icrl_pkg::STAT_ADDR, 32'h81, "status reset");
      rchk(icrl_pkg::IRQ_MASK_ADDR, 32'h0, "mask reset");
      rchk(icrl_pkg::CTRL_ADDR + 32'h4, 32'h0, "hole read");
      `CHK("hole error", 1'b1, err)
      for (i = 0; i < 4; i++)
      begin
         v = 32'($random(seed)) & 32'hFFFFFF7F;
         apb(1'b1, icrl_pkg::CTRL_ADDR, v);
         rchk(icrl_pkg::CTRL_ADDR, v & 32'h78, "ctrl inert");
         `CHK("lines idle", 3'b000, {scl_oe, sda_oe, irq})
      end
      $display("test registers done");
      // master write: address, then data
      apb(1'b1, icrl_pkg::IRQ_MASK_ADDR, 32'h80);
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hD0);
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hF0);
      byte_go({PEER, 1'b0});
      `CHK("addr ack", 1'b0, rd[0])
      rchk(icrl_pkg::IRQ_STAT_ADDR, 32'h80, "addr event");
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hB8);
      mstr <= 4'($random(seed));
      b = 8'($random(seed));
      sent.push_back(b);
      byte_go(b);
      `CHK("irq gated", 1'b0, irq)
      `CHK("data ack", 1'b0, rd[0])
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hF0);
      @(posedge clk);
      `CHK("irq pending", 1'b1, irq)
      rchk(icrl_pkg::IRQ_STAT_ADDR, 32'h80, "pending kept");
      `CHK("peer count", 1, peer.got.size())
      `CHK("peer data", sent[0], peer.got[0])
      $display("test master write done");
      // restart, read acked and refused bytes, stop
      direction_transmit <= 8'($random(seed));
      n = peer.n_start;
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hF4);
      rchk(icrl_pkg::CTRL_ADDR, 32'hF0, "restart reads 0");
      for (k = 0; k < 3000 && peer.n_start == n; k++) @(posedge clk);
      byte_go({PEER, 1'b1});
      apb(1'b0, icrl_pkg::IRQ_STAT_ADDR, 32'h0);
      for (i = 0; i < 2; i++)
      begin
         apb(1'b1, icrl_pkg::CTRL_ADDR, i == 0 ? 32'hE0 : 32'hE8);
         byte_go(8'hFF);
         `CHK("rx byte", direction_transmit, rxd)
         `CHK("ack bit", i[0], peer.last_ack)
      end
      n = peer.n_stop;
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hC8);
      for (k = 0; k < 3000 && peer.n_stop == n; k++) @(posedge clk);
      `CHK("stop seen", n + 1, peer.n_stop)
      $display("test master read done");
      // restart while not master loses arbitration
      apb(1'b0, icrl_pkg::IRQ_STAT_ADDR, 32'h0);
      apb(1'b1, icrl_pkg::IRQ_MASK_ADDR, 32'h10);
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'hC4);
      for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
      rchk(icrl_pkg::IRQ_STAT_ADDR, 32'h10, "arb lost");
      apb(1'b1, icrl_pkg::CTRL_ADDR, 32'h0);
      repeat (3) @(posedge clk);
      `CHK("off idle", 3'b000, {scl_oe, sda_oe, irq})
      $display("test slave restart done");
      complete_run();
   end
endmodule : tb_i2c_control_register_logic
